// ---- dv/scc_top_props.sv ----
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_top_props
    import scc_pkg::*;
#(
    parameter int          PPS_COUNT   = 8,
    parameter int          PPS_WIDTH   = 4,
    parameter int          PMD_COUNT   = 2,
    parameter logic [3:0]  REVISION    = 4'h1,
    parameter logic [27:0] DEVICE_CODE = 28'h0A5C3E1,
    parameter bit          LARGE_FLASH = 1'b0
)
(
    input wire logic                           sys_clk,
    input wire logic                           reset,
    input wire logic [15:0]                    reg_addr,
    input wire logic [31:0]                    reg_wdata,
    input wire logic                           reg_wr,
    input wire logic                           reg_rd,
    input wire logic [31:0]                    reg_rdata,
    input wire logic                           unlock_open,
    input wire logic                           scan_port_enable,
    input wire logic                           two_wire_output_select,
    input wire logic                           pin_select_lock,
    input wire logic                           module_disable_lock,
    input wire logic [PPS_COUNT*PPS_WIDTH-1:0] pin_select_map,
    input wire logic [PMD_COUNT*32-1:0]        module_disable_map
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic key_1;
    logic key_2;
    logic wr_ctl;
    assign key_1  = reg_wr && reg_addr == `SCC_OFF_UNLOCK_KEY
                    && reg_wdata == `SCC_UNLOCK_KEY_FIRST;
    assign key_2  = reg_wr && reg_addr == `SCC_OFF_UNLOCK_KEY
                    && reg_wdata == `SCC_UNLOCK_KEY_SECOND;
    assign wr_ctl = reg_wr && reg_addr == `SCC_OFF_CONFIG_CONTROL;

    a_pps_lock_hold: assert property (
        pin_select_lock |=> $stable(pin_select_map))
        else $error("pin map changed while locked");
    a_pps_write_lands: assert property (
        reg_wr && !pin_select_lock && reg_addr == `SCC_OFF_PIN_SELECT_BASE
        |=> pin_select_map[3:0] == $past(reg_wdata[3:0]))
        else $error("pin map write lost");
    a_pmd_lock_hold: assert property (
        module_disable_lock |=> $stable(module_disable_map))
        else $error("disable map changed while locked");
    a_pmd_write_lands: assert property (
        reg_wr && !module_disable_lock
        && reg_addr == `SCC_OFF_MOD_DISABLE_BASE
        |=> module_disable_map[31:0] == $past(reg_wdata))
        else $error("disable map write lost");
    a_scan_enable: assert property (
        wr_ctl |=> scan_port_enable == $past(reg_wdata[3]))
        else $error("scan enable not written");
    a_two_wire_sel: assert property (
        wr_ctl |=> two_wire_output_select == $past(reg_wdata[0]))
        else $error("two wire select not written");
    a_ctl_readback: assert property (
        reg_rd && reg_addr == `SCC_OFF_CONFIG_CONTROL
        |=> reg_rdata == {18'h0, pin_select_lock, module_disable_lock,
            8'h0, scan_port_enable, 2'h1, two_wire_output_select})
        else $error("control readback wrong");
    a_lock_gate: assert property (
        !unlock_open |=> $stable({pin_select_lock, module_disable_lock}))
        else $error("lock changed while gate closed");
    a_key_opens: assert property (
        key_1 ##1 !reg_wr ##1 key_2 |=> unlock_open)
        else $error("gate not opened by keys");
    a_ident_read: assert property (
        reg_rd && reg_addr == `SCC_OFF_PART_IDENT
        |=> reg_rdata == {REVISION, DEVICE_CODE})
        else $error("identification wrong");
    a_pwp_absent: assert property (
        reg_rd && reg_addr == `SCC_OFF_CFG_WORD_0 && !LARGE_FLASH
        |=> reg_rdata[18:17] == 2'h0)
        else $error("absent protect bits read set");
endmodule

// ---- dv/scc_top_test.sv ----
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_top_test;
    localparam logic [3:0]  REV  = 4'h1;       // arbitrary value
    localparam logic [27:0] CODE = 28'h0A5C3E1; // arbitrary value
    localparam logic [31:0] K1   = `SCC_UNLOCK_KEY_FIRST;
    localparam logic [31:0] K2   = `SCC_UNLOCK_KEY_SECOND;
    localparam logic [31:0] PWPM = `SCC_PWP_HI_MASK;

    logic        sys_clk   = 1'b0;
    logic        reset     = 1'b1;
    logic [15:0] reg_addr  = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] nvm_rdata = 32'h0000_0000;
    wire  [31:0] reg_rdata;
    wire         nvm_rd;
    wire  [1:0]  nvm_addr;
    wire         words_ok;
    wire         unlock_open;
    wire  [3:0]  ctl;
    wire  [31:0] pps_map;
    wire  [63:0] pmd_map;
    logic [31:0] cfg_w [4] = '{32'hFFFF_FFFF, 32'h1234_5678,
                               32'h9ABC_DEF0, 32'h0F1E_2D3C};
    int          errors     = 0;
    int          num_checks = 0;
    int          i;

    scc_top #(.REVISION(REV), .DEVICE_CODE(CODE)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr),
        .nvm_rdata(nvm_rdata), .config_words_valid(words_ok),
        .unlock_open(unlock_open), .scan_port_enable(ctl[1]),
        .two_wire_output_select(ctl[0]), .pin_select_lock(ctl[3]),
        .module_disable_lock(ctl[2]), .pin_select_map(pps_map),
        .module_disable_map(pmd_map));

    initial forever #10 sys_clk = ~sys_clk;

    // data held one cycle after the fetch, then scrambled
    always @(posedge sys_clk)
        nvm_rdata <= nvm_rd ? cfg_w[nvm_addr] : ~nvm_rdata;

    task automatic complete_run;
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    initial
    begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        chk({28'h0, ctl}, 32'h3);
        rd(16'hF200, `SCC_CTL_RESET);
        rd(16'hF220, {REV, CODE});
        rd(16'hF230, `SCC_KEY_RESET);
        rd(16'hF210, `SCC_UNMAPPED_READ);
        for (i = 0; i < 50 && words_ok !== 1'b1; i++)
            @(posedge sys_clk);
        if (words_ok !== 1'b1)
        begin
            errors++;
            complete_run();
        end
        for (i = 0; i < 4; i++)
            rd(16'h0BFC - 16'(4 * i), i == 0 ? cfg_w[0] & ~PWPM : cfg_w[i]);
        wr(16'h0BFC, 32'h0000_0000);
        rd(16'h0BFC, cfg_w[0] & ~PWPM);
        wr(16'hF200, 32'h0000_3000);
        rd(16'hF200, 32'h0000_0002);
        wr(16'hF200, 32'h0000_0009);
        chk({28'h0, ctl}, 32'h3);
        wr(16'hF31C, 32'h0000_00F5);
        chk({28'h0, pps_map[31:28]}, 32'h5);
        rd(16'hF31C, 32'h0000_0005);
        wr(16'hF400, 32'h1357_9BDF);
        chk(pmd_map[31:0], 32'h1357_9BDF);
        wr(16'hF404, 32'hA5A5_5A5A);
        chk(pmd_map[63:32], 32'hA5A5_5A5A);
        wr(16'hF230, K1);
        wr(16'hF230, K2);
        chk({31'h0, unlock_open}, 32'h1);
        wr(16'hF200, 32'h0000_300B);
        rd(16'hF200, 32'h0000_300B);
        wr(16'hF300, 32'h0000_0007);
        chk({28'h0, pps_map[3:0]}, 32'h0);
        wr(16'hF404, 32'h0000_0000);
        chk(pmd_map[63:32], 32'hA5A5_5A5A);
        // a stray write between the keys must abort the sequence
        wr(16'hF230, K1);
        wr(16'hF300, 32'h0000_0001);
        wr(16'hF230, K2);
        chk({31'h0, unlock_open}, 32'h0);
        wr(16'hF200, 32'h0000_0008);
        chk({28'h0, ctl}, 32'hE);
        wr(16'hF230, K1);
        wr(16'hF230, K2);
        wr(16'hF200, 32'h0000_0001);
        chk({28'h0, ctl}, 32'h1);
        wr(16'hF300, 32'h0000_0007);
        chk({28'h0, pps_map[3:0]}, 32'h7);
        complete_run();
    end
endmodule

bind scc_top scc_top_props #(
    .PPS_COUNT(PPS_COUNT), .PPS_WIDTH(PPS_WIDTH), .PMD_COUNT(PMD_COUNT),
    .REVISION(REVISION), .DEVICE_CODE(DEVICE_CODE),
    .LARGE_FLASH(LARGE_FLASH)
) u_props (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .unlock_open(unlock_open),
    .scan_port_enable(scan_port_enable),
    .two_wire_output_select(two_wire_output_select),
    .pin_select_lock(pin_select_lock),
    .module_disable_lock(module_disable_lock),
    .pin_select_map(pin_select_map),
    .module_disable_map(module_disable_map));

// ---- verilog/scc_cfg.svh ----
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

// register byte offsets
`define SCC_OFF_CFG_WORD_3      16'h0BF0
`define SCC_OFF_CFG_WORD_2      16'h0BF4
`define SCC_OFF_CFG_WORD_1      16'h0BF8
`define SCC_OFF_CFG_WORD_0      16'h0BFC
`define SCC_OFF_CONFIG_CONTROL  16'hF200
`define SCC_OFF_PART_IDENT      16'hF220
`define SCC_OFF_UNLOCK_KEY      16'hF230
`define SCC_OFF_PIN_SELECT_BASE 16'hF300
`define SCC_OFF_MOD_DISABLE_BASE 16'hF400

// config_control field positions
`define SCC_BIT_PIN_SELECT_LOCK 13
`define SCC_BIT_MOD_DISABLE_LOCK 12
`define SCC_BIT_SCAN_PORT_EN    3
`define SCC_BIT_TWO_WIRE_SEL    0
`define SCC_CTL_ONES_MASK       32'h0000_0002
`define SCC_CTL_RESET           32'h0000_000B

// part identification layout
`define SCC_REV_LSB             28

// flash write protect upper bits in config word 0
`define SCC_PWP_HI_MASK         32'h0006_0000

// unlock sequence keys
`define SCC_UNLOCK_KEY_FIRST    32'h3C5A_96E1
`define SCC_UNLOCK_KEY_SECOND   32'hE196_5A3C
`define SCC_KEY_RESET           32'h0000_0000

// config word load
`define SCC_CFG_WORD_COUNT      4
`define SCC_UNMAPPED_READ       32'h0000_0000

`endif

// ---- verilog/scc_loader.sv ----
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_loader
    import scc_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    output wire logic              nvm_rd,
    output wire logic [1:0]        nvm_addr,
    input  wire logic [31:0]       nvm_rdata,
    output scc_cfg_words_type      words,
    output wire logic              words_valid
);

    scc_load_state_type state_q;
    scc_load_state_type state_d;
    logic [1:0]         idx_q;
    logic [1:0]         idx_d;
    scc_cfg_words_type  words_q;
    scc_cfg_words_type  words_d;
    logic               rd_q;
    logic               rd_d;

    // one word per request, data back one cycle after the strobe
    always_comb
    begin
        state_d = state_q;
        idx_d   = idx_q;
        words_d = words_q;
        rd_d    = 1'b0;
        case (state_q)
            LD_READ:
            begin
                rd_d    = 1'b1;
                state_d = LD_WAIT;
            end
            LD_WAIT:
            begin
                if (!rd_q)
                begin
                    words_d[idx_q] = nvm_rdata;
                    if (idx_q == 2'(`SCC_CFG_WORD_COUNT - 1))
                        state_d = LD_DONE;
                    else
                    begin
                        idx_d   = idx_q + 2'h1;
                        state_d = LD_READ;
                    end
                end
            end
            LD_DONE:
            begin
                state_d = LD_DONE;
            end
            default:
            begin
                state_d = LD_READ;
            end
        endcase
    end

    // words are not cleared: their value before loading is undefined
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q <= LD_READ;
            idx_q   <= 2'h0;
            rd_q    <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            idx_q   <= idx_d;
            rd_q    <= rd_d;
        end
        words_q <= words_d;
    end

    assign nvm_rd      = rd_q;
    assign nvm_addr    = idx_q;
    assign words       = words_q;
    assign words_valid = (state_q == LD_DONE);

endmodule

// ---- verilog/scc_pkg.sv ----
package scc_pkg;

    typedef struct packed {
        logic pin_select_lock;
        logic module_disable_lock;
        logic scan_port_enable;
        logic two_wire_output_select;
    } scc_ctl_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } scc_bus_req_type;

    typedef logic [3:0][31:0] scc_cfg_words_type;

    typedef enum logic [1:0] {
        UNL_IDLE  = 2'b00,
        UNL_FIRST = 2'b01,
        UNL_OPEN  = 2'b11
    } scc_unlock_state_type;

    typedef enum logic [1:0] {
        LD_READ = 2'b00,
        LD_WAIT = 2'b01,
        LD_DONE = 2'b11
    } scc_load_state_type;

endpackage

// ---- verilog/scc_top.sv ----
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_top
    import scc_pkg::*;
#(
    parameter int          PPS_COUNT   = 8,
    parameter int          PPS_WIDTH   = 4,
    parameter int          PMD_COUNT   = 2,
    parameter logic [3:0]  REVISION    = 4'h1,       // arbitrary value
    parameter logic [27:0] DEVICE_CODE = 28'h0A5C3E1, // arbitrary value
    parameter bit          LARGE_FLASH = 1'b0
)
(
    input  wire logic                           sys_clk,
    input  wire logic                           reset,
    input  wire logic [15:0]                    reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output wire logic [31:0]                    reg_rdata,
    output wire logic                           nvm_rd,
    output wire logic [1:0]                     nvm_addr,
    input  wire logic [31:0]                    nvm_rdata,
    output wire logic                           config_words_valid,
    output wire logic                           unlock_open,
    output wire logic                           scan_port_enable,
    output wire logic                           two_wire_output_select,
    output wire logic                           pin_select_lock,
    output wire logic                           module_disable_lock,
    output wire logic [PPS_COUNT*PPS_WIDTH-1:0] pin_select_map,
    output wire logic [PMD_COUNT*32-1:0]        module_disable_map
);

    scc_bus_req_type   req;
    scc_ctl_type       ctl_q;
    scc_ctl_type       ctl_d;
    logic [31:0]       key_q;
    logic [31:0]       key_d;
    logic [31:0]       rdata_q;
    logic [31:0]       rdata_d;
    logic [PPS_COUNT-1:0][PPS_WIDTH-1:0] pps_q;
    logic [PPS_COUNT-1:0][PPS_WIDTH-1:0] pps_d;
    logic [PMD_COUNT-1:0][31:0]          pmd_q;
    logic [PMD_COUNT-1:0][31:0]          pmd_d;
    scc_cfg_words_type cfg_words;
    logic              cfg_valid;
    logic              unlocked;
    logic              key_wr;
    logic              other_wr;

    function automatic logic in_bank(
        input logic [15:0] a,
        input logic [15:0] base,
        input int          count
    );
        int ia;
        int ib;
        ia = int'(a);
        ib = int'(base);
        return (a[1:0] == 2'b00) && (ia >= ib) && (ia < ib + count * 4);
    endfunction

    function automatic int slot_of(
        input logic [15:0] a,
        input logic [15:0] base
    );
        return (int'(a) - int'(base)) / 4;
    endfunction

    function automatic logic [31:0] ctl_word(input scc_ctl_type c);
        logic [31:0] w;
        w = `SCC_CTL_ONES_MASK;
        w[`SCC_BIT_PIN_SELECT_LOCK]  = c.pin_select_lock;
        w[`SCC_BIT_MOD_DISABLE_LOCK] = c.module_disable_lock;
        w[`SCC_BIT_SCAN_PORT_EN]     = c.scan_port_enable;
        w[`SCC_BIT_TWO_WIRE_SEL]     = c.two_wire_output_select;
        return w;
    endfunction

    assign req.addr  = reg_addr;
    assign req.wdata = reg_wdata;
    assign req.wr    = reg_wr;
    assign req.rd    = reg_rd;

    assign key_wr   = req.wr && (req.addr == `SCC_OFF_UNLOCK_KEY);
    assign other_wr = req.wr && (req.addr != `SCC_OFF_UNLOCK_KEY);

    scc_unlock u_unlock
    (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .key_wr   (key_wr),
        .other_wr (other_wr),
        .key_data (req.wdata),
        .unlocked (unlocked)
    );

    scc_loader u_loader
    (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .nvm_rd      (nvm_rd),
        .nvm_addr    (nvm_addr),
        .nvm_rdata   (nvm_rdata),
        .words       (cfg_words),
        .words_valid (cfg_valid)
    );

    // control and key registers
    always_comb
    begin
        ctl_d = ctl_q;
        key_d = key_q;
        if (req.wr && req.addr == `SCC_OFF_CONFIG_CONTROL)
        begin
            ctl_d.scan_port_enable =
                req.wdata[`SCC_BIT_SCAN_PORT_EN];
            ctl_d.two_wire_output_select =
                req.wdata[`SCC_BIT_TWO_WIRE_SEL];
            // locks move only while the key gate is open
            if (unlocked)
            begin
                ctl_d.pin_select_lock =
                    req.wdata[`SCC_BIT_PIN_SELECT_LOCK];
                ctl_d.module_disable_lock =
                    req.wdata[`SCC_BIT_MOD_DISABLE_LOCK];
            end
        end
        if (key_wr)
            key_d = req.wdata;
    end

    // pin-select and module-disable banks
    always_comb
    begin
        pps_d = pps_q;
        pmd_d = pmd_q;
        if (req.wr && !ctl_q.pin_select_lock &&
            in_bank(req.addr, `SCC_OFF_PIN_SELECT_BASE, PPS_COUNT))
        begin
            pps_d[slot_of(req.addr, `SCC_OFF_PIN_SELECT_BASE)] =
                req.wdata[PPS_WIDTH-1:0];
        end
        if (req.wr && !ctl_q.module_disable_lock &&
            in_bank(req.addr, `SCC_OFF_MOD_DISABLE_BASE, PMD_COUNT))
        begin
            pmd_d[slot_of(req.addr, `SCC_OFF_MOD_DISABLE_BASE)] = req.wdata;
        end
    end

    // read data, valid only in the cycle after the strobe
    always_comb
    begin
        rdata_d = `SCC_UNMAPPED_READ;
        if (req.rd)
        begin
            if (in_bank(req.addr, `SCC_OFF_PIN_SELECT_BASE, PPS_COUNT))
            begin
                rdata_d[PPS_WIDTH-1:0] =
                    pps_q[slot_of(req.addr, `SCC_OFF_PIN_SELECT_BASE)];
            end
            else if (in_bank(req.addr, `SCC_OFF_MOD_DISABLE_BASE,
                             PMD_COUNT))
            begin
                rdata_d =
                    pmd_q[slot_of(req.addr, `SCC_OFF_MOD_DISABLE_BASE)];
            end
            else
            begin
                case (req.addr)
                    `SCC_OFF_CFG_WORD_3:
                        rdata_d = cfg_words[3];
                    `SCC_OFF_CFG_WORD_2:
                        rdata_d = cfg_words[2];
                    `SCC_OFF_CFG_WORD_1:
                        rdata_d = cfg_words[1];
                    `SCC_OFF_CFG_WORD_0:
                    begin
                        rdata_d = cfg_words[0];
                        // smaller parts have no upper protect bits
                        if (!LARGE_FLASH)
                            rdata_d = rdata_d & ~`SCC_PWP_HI_MASK;
                    end
                    `SCC_OFF_CONFIG_CONTROL:
                        rdata_d = ctl_word(ctl_q);
                    `SCC_OFF_PART_IDENT:
                    begin
                        rdata_d[31:`SCC_REV_LSB]  = REVISION;
                        rdata_d[`SCC_REV_LSB-1:0] = DEVICE_CODE;
                    end
                    `SCC_OFF_UNLOCK_KEY:
                        rdata_d = key_q;
                    default:
                        rdata_d = `SCC_UNMAPPED_READ;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctl_q   <= scc_ctl_type'({
                          1'b0, 1'b0, 1'b1, 1'b1});
            key_q   <= `SCC_KEY_RESET;
            rdata_q <= `SCC_UNMAPPED_READ;
            pps_q   <= '0;
            pmd_q   <= '0;
        end
        else
        begin
            ctl_q   <= ctl_d;
            key_q   <= key_d;
            rdata_q <= rdata_d;
            pps_q   <= pps_d;
            pmd_q   <= pmd_d;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PPS_COUNT; gi++)
        begin : g_pps
            assign pin_select_map[gi*PPS_WIDTH +: PPS_WIDTH] = pps_q[gi];
        end
        for (gi = 0; gi < PMD_COUNT; gi++)
        begin : g_pmd
            assign module_disable_map[gi*32 +: 32] = pmd_q[gi];
        end
    endgenerate

    assign reg_rdata              = rdata_q;
    assign config_words_valid     = cfg_valid;
    assign unlock_open            = unlocked;
    assign scan_port_enable       = ctl_q.scan_port_enable;
    assign two_wire_output_select = ctl_q.two_wire_output_select;
    assign pin_select_lock        = ctl_q.pin_select_lock;
    assign module_disable_lock    = ctl_q.module_disable_lock;

endmodule

// ---- verilog/scc_unlock.sv ----
`timescale 1ns/1ps
`include "scc_cfg.svh"

module scc_unlock
    import scc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        key_wr,
    input  wire logic        other_wr,
    input  wire logic [31:0] key_data,
    output wire logic        unlocked
);

    scc_unlock_state_type state_q;
    scc_unlock_state_type state_d;

    // two key writes back to back; any other write in between aborts
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            UNL_IDLE:
            begin
                if (key_wr && key_data == `SCC_UNLOCK_KEY_FIRST)
                    state_d = UNL_FIRST;
            end
            UNL_FIRST:
            begin
                if (key_wr && key_data == `SCC_UNLOCK_KEY_SECOND)
                    state_d = UNL_OPEN;
                else if (key_wr || other_wr)
                    state_d = UNL_IDLE;
            end
            UNL_OPEN:
            begin
                // any key write closes the gate; a first key restarts
                if (key_wr && key_data == `SCC_UNLOCK_KEY_FIRST)
                    state_d = UNL_FIRST;
                else if (key_wr)
                    state_d = UNL_IDLE;
            end
            default:
            begin
                state_d = UNL_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            state_q <= UNL_IDLE;
        else
            state_q <= state_d;
    end

    assign unlocked = (state_q == UNL_OPEN);

endmodule
